/* core/lce_eval.sv */
// scan-stepped evaluator for coils, inversion, pause, one-shots and latches
//
// Summary of operation
// (R1) output on if any OR-combining rung driving it is on
// (R2) bit-of-word coil writes rung status into selected bit 0 to 15
// (R3) program must not drive one word bit from two coils; last wins
// (R4) inversion complements accumulated rung status at its position
// (R5) pause forces range off at output module; image still updates
// (R6) rising one-shot coil is on exactly one scan per off-to-on rung
// (R7) rising start contact closes one scan on point off-to-on
// (R8) rising start contact on retentive point also closes at run entry
// (R9) falling start contact closes one scan on point on-to-off
// (R10) rising parallel contact ORs in one scan pulse on off-to-on
// (R11) falling parallel contact ORs in one scan pulse on on-to-off
// (R12) rising series contact ANDs in one scan pulse on off-to-on
// (R13) falling series contact ANDs in one scan pulse on on-to-off
// (R14) set turns on point or range and it stays on
// (R15) clear turns off point or range and it stays off; the code lets set win when set and clear are on in one scan
// (R16) every edge instruction keeps its own previous-scan copy
`default_nettype none
module lce_eval
(
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic [3:0] i_or_rungs,
    input wire logic [15:0] i_or_target_sel,
    input wire logic i_bow_rung,
    input wire logic [3:0] i_bow_bit,
    input wire logic i_bow_rung_last,
    input wire logic [3:0] i_bow_bit_last,
    input wire logic i_inv_rung,
    input wire logic i_pause_rung,
    input wire logic [15:0] i_pause_range,
    input wire logic i_os_rung,
    input wire logic i_ref_point,
    input wire logic i_ref_retentive,
    input wire logic i_branch_rung,
    input wire logic i_set_rung,
    input wire logic i_clr_rung,
    input wire logic [15:0] i_latch_range,
    output logic [15:0] o_out_image,
    output logic [15:0] o_out_module,
    output logic [15:0] o_word,
    output logic o_inv_status,
    output logic o_rising_one_shot_coil,
    output logic o_rising_edge_start_contact,
    output logic o_falling_edge_start_contact,
    output logic o_rising_edge_parallel_contact,
    output logic o_falling_edge_parallel_contact,
    output logic o_rising_edge_series_contact,
    output logic o_falling_edge_series_contact,
    output logic [15:0] o_latch_image
);
    typedef struct packed
    {
        lce_pkg::lce_mode_type mode;
        logic [15:0] out_image;
        logic [15:0] out_module;
        logic [15:0] word;
        logic inv_status;
        logic os_prev;
        logic os_coil;
        logic rs_prev;
        logic rs_out;
        logic fs_prev;
        logic fs_out;
        logic rp_prev;
        logic rp_out;
        logic fp_prev;
        logic fp_out;
        logic ra_prev;
        logic ra_out;
        logic fa_prev;
        logic fa_out;
        logic [15:0] latch_image;
    } lce_state_type;

    lce_state_type state_ff;
    lce_state_type nxt_state;
    // edge history clears, so a point high at run entry reads as a rise
    localparam lce_state_type STATE_RESET = '{
        mode: lce_pkg::ST_RUN_ENTRY,
        out_image: lce_pkg::OUT_RESET,
        out_module: lce_pkg::OUT_RESET,
        word: lce_pkg::WORD_RESET,
        inv_status: 1'b0,
        os_prev: lce_pkg::EDGE_RESET,
        os_coil: 1'b0,
        rs_prev: lce_pkg::EDGE_RESET,
        rs_out: 1'b0,
        fs_prev: lce_pkg::EDGE_RESET,
        fs_out: 1'b0,
        rp_prev: lce_pkg::EDGE_RESET,
        rp_out: 1'b0,
        fp_prev: lce_pkg::EDGE_RESET,
        fp_out: 1'b0,
        ra_prev: lce_pkg::EDGE_RESET,
        ra_out: 1'b0,
        fa_prev: lce_pkg::EDGE_RESET,
        fa_out: 1'b0,
        latch_image: lce_pkg::OUT_RESET
    };

    function automatic logic rise(input logic cur, input logic prev);
        return cur & ~prev;
    endfunction

    function automatic logic fall(input logic cur, input logic prev);
        return ~cur & prev;
    endfunction

    always_comb
    begin
        logic any_or;
        logic [15:0] img;
        logic entry;
        any_or = |i_or_rungs;
        img = 16'h0000;
        entry = (state_ff.mode == lce_pkg::ST_RUN_ENTRY);
        nxt_state = state_ff;
        nxt_state.mode = lce_pkg::ST_RUN;
        img = any_or ? i_or_target_sel : 16'h0000; // R1
        nxt_state.out_image = img;
        nxt_state.out_module = img & ~(i_pause_rung ? i_pause_range
            : 16'h0000); // R5
        nxt_state.word[i_bow_bit] = i_bow_rung; // R2
        nxt_state.word[i_bow_bit_last] = i_bow_rung_last; // R3
        nxt_state.inv_status = ~i_inv_rung; // R4
        nxt_state.os_prev = i_os_rung; // R16
        nxt_state.os_coil = rise(i_os_rung, state_ff.os_prev); // R6
        nxt_state.rs_prev = i_ref_point; // R16
        nxt_state.rs_out = rise(i_ref_point, state_ff.rs_prev)
            | (entry & i_ref_retentive); // R7 R8
        nxt_state.fs_prev = i_ref_point; // R16
        nxt_state.fs_out = fall(i_ref_point, state_ff.fs_prev); // R9
        nxt_state.rp_prev = i_ref_point;
        nxt_state.rp_out = i_branch_rung
            | rise(i_ref_point, state_ff.rp_prev); // R10
        nxt_state.fp_prev = i_ref_point;
        nxt_state.fp_out = i_branch_rung
            | fall(i_ref_point, state_ff.fp_prev); // R11
        nxt_state.ra_prev = i_ref_point;
        nxt_state.ra_out = i_branch_rung
            & rise(i_ref_point, state_ff.ra_prev); // R12
        nxt_state.fa_prev = i_ref_point;
        nxt_state.fa_out = i_branch_rung
            & fall(i_ref_point, state_ff.fa_prev); // R13
        if (i_set_rung)
        begin
            nxt_state.latch_image = state_ff.latch_image
                | i_latch_range; // R14
        end
        else if (i_clr_rung)
        begin
            nxt_state.latch_image = state_ff.latch_image
                & ~i_latch_range; // R15
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state_ff <= STATE_RESET;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    assign o_out_image = state_ff.out_image;
    assign o_out_module = state_ff.out_module;
    assign o_word = state_ff.word;
    assign o_inv_status = state_ff.inv_status;
    assign o_rising_one_shot_coil = state_ff.os_coil;
    assign o_rising_edge_start_contact = state_ff.rs_out;
    assign o_falling_edge_start_contact = state_ff.fs_out;
    assign o_rising_edge_parallel_contact = state_ff.rp_out;
    assign o_falling_edge_parallel_contact = state_ff.fp_out;
    assign o_rising_edge_series_contact = state_ff.ra_out;
    assign o_falling_edge_series_contact = state_ff.fa_out;
    assign o_latch_image = state_ff.latch_image;

    property p_or_out;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (|i_or_rungs) |=> (o_out_image == $past(i_or_target_sel));
    endproperty
    a_or_out: assert property (p_or_out) else $error("or coil wrong"); // R1

    property p_or_off;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        !(|i_or_rungs) |=> (o_out_image == 16'h0000);
    endproperty
    a_or_off: assert property (p_or_off) else $error("or coil stuck"); // R1

    property p_bow;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (i_bow_bit != i_bow_bit_last) |=>
            (o_word[$past(i_bow_bit)] == $past(i_bow_rung));
    endproperty
    a_bow: assert property (p_bow) else $error("word bit wrong"); // R2

    property p_bow_last;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        1'b1 |=> (o_word[$past(i_bow_bit_last)] == $past(i_bow_rung_last));
    endproperty
    a_bow_last: assert property (p_bow_last) else $error("last coil"); // R3

    property p_inv;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        i_inv_rung |=> !o_inv_status;
    endproperty
    a_inv: assert property (p_inv) else $error("inversion wrong"); // R4

    property p_inv_off;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        !i_inv_rung |=> o_inv_status;
    endproperty
    a_inv_off: assert property (p_inv_off) else $error("inversion off"); // R4

    property p_pause;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        i_pause_rung |=> ((o_out_module & $past(i_pause_range)) == 16'h0000)
            && (o_out_image == ($past(|i_or_rungs) ? $past(i_or_target_sel)
            : 16'h0000));
    endproperty
    a_pause: assert property (p_pause) else $error("pause wrong"); // R5

    property p_no_pause;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        !i_pause_rung |=> (o_out_module == o_out_image);
    endproperty
    a_no_pause: assert property (p_no_pause) else $error("pause leak"); // R5

    sequence s_rung_rise;
        !i_os_rung ##1 i_os_rung;
    endsequence
    sequence s_ref_rise;
        !i_ref_point ##1 i_ref_point;
    endsequence
    sequence s_ref_fall;
        i_ref_point ##1 !i_ref_point;
    endsequence
    property p_one_shot;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        s_rung_rise |=> o_rising_one_shot_coil ##1 !o_rising_one_shot_coil;
    endproperty
    a_one_shot: assert property (p_one_shot) else $error("one shot"); // R6

    property p_rise_start;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        s_ref_rise |=> o_rising_edge_start_contact;
    endproperty
    a_rise_start: assert property (p_rise_start) else $error("rise"); // R7

    property p_entry;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        ((state_ff.mode == lce_pkg::ST_RUN_ENTRY) && i_ref_retentive)
            |=> o_rising_edge_start_contact;
    endproperty
    a_entry: assert property (p_entry) else $error("run entry"); // R8

    property p_fall_pulse;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        s_ref_fall |=> o_falling_edge_start_contact;
    endproperty
    a_fall_pulse: assert property (p_fall_pulse) else $error("fall"); // R9

    property p_fall_start;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (i_ref_point ##1 i_ref_point) |=> !o_falling_edge_start_contact;
    endproperty
    a_fall_start: assert property (p_fall_start) else $error("no fall"); // R9

    property p_series;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        !i_branch_rung |=> !o_rising_edge_series_contact
            && !o_falling_edge_series_contact;
    endproperty
    a_series: assert property (p_series) else $error("series pass"); // R12

    property p_par_rise;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        s_ref_rise |=> o_rising_edge_parallel_contact;
    endproperty
    a_par_rise: assert property (p_par_rise) else $error("par rise"); // R10

    property p_par_fall;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        s_ref_fall |=> o_falling_edge_parallel_contact;
    endproperty
    a_par_fall: assert property (p_par_fall) else $error("par fall"); // R11

    property p_par_branch;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        i_branch_rung |=> o_rising_edge_parallel_contact
            && o_falling_edge_parallel_contact;
    endproperty
    a_par_branch: assert property (p_par_branch) else $error("par or"); // R10

    property p_ser_rise;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (s_ref_rise ##0 i_branch_rung) |=> o_rising_edge_series_contact;
    endproperty
    a_ser_rise: assert property (p_ser_rise) else $error("ser rise"); // R12

    property p_ser_fall;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (s_ref_fall ##0 i_branch_rung) |=> o_falling_edge_series_contact;
    endproperty
    a_ser_fall: assert property (p_ser_fall) else $error("ser fall"); // R13

    property p_set;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (i_set_rung ##1 (!i_set_rung && !i_clr_rung))
            |=> ((o_latch_image & $past(i_latch_range, 2)) ==
            $past(i_latch_range, 2));
    endproperty
    a_set: assert property (p_set) else $error("latch lost"); // R14

    property p_set_wins;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (i_set_rung && i_clr_rung)
            |=> ((~o_latch_image & $past(i_latch_range)) == 16'h0000);
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("set wins"); // R14

    property p_clr;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (i_clr_rung && !i_set_rung)
            |=> ((o_latch_image & $past(i_latch_range)) == 16'h0000);
    endproperty
    a_clr: assert property (p_clr) else $error("clear failed"); // R15
endmodule
`default_nettype wire

/* core/lce_pkg.sv */
// package for the ladder coil and edge contact evaluator
`default_nettype none
package lce_pkg;
    localparam int unsigned NUM_OUT = 16;
    localparam int unsigned WORD_W = 16;
    localparam int unsigned BIT_IDX_W = 4;
    localparam int unsigned NUM_RUNG = 4;
    localparam logic [15:0] OUT_RESET = 16'h0000;
    localparam logic [15:0] WORD_RESET = 16'h0000;
    localparam logic [3:0] RUNG_RESET = 4'h0;
    localparam logic [0:0] EDGE_RESET = 1'h0;
    typedef enum logic [1:0]
    {
        ST_RUN_ENTRY = 2'b00,
        ST_RUN = 2'b01
    } lce_mode_type;
endpackage
`default_nettype wire

/* verification/lce_out_model.sv */
// output module model: latches the pause-masked drive each scan
`default_nettype none
module lce_out_model
(
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic [15:0] i_drive,
    output logic [15:0] o_field
);
    timeunit 1ns;
    timeprecision 1ns;
    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_field <= 16'h0000;
        else
            o_field <= i_drive;
    end
endmodule
`default_nettype wire

/* verification/ladder_coil_and_edge_contact_eval_tb_top.sv */
// self-checking bench for the coil and edge contact evaluator
`default_nettype none
module ladder_coil_and_edge_contact_eval_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed
    {
        logic [3:0] r;
        logic [15:0] s;
        logic [15:0] p;
        logic pz;
        logic iv;
        logic [15:0] ei;
        logic [15:0] em;
    } lce_row_type;
    lce_row_type rows [5] = '{
        '{4'h0, 16'hFFFF, 16'h0000, 1'b0, 1'b0, 16'h0000, 16'h0000},
        '{4'h1, 16'h00F0, 16'h0000, 1'b0, 1'b1, 16'h00F0, 16'h00F0},
        '{4'h8, 16'hF00F, 16'hFF00, 1'b0, 1'b0, 16'hF00F, 16'hF00F},
        '{4'h6, 16'hF00F, 16'hFF00, 1'b1, 1'b1, 16'hF00F, 16'h000F},
        '{4'hF, 16'hFFFF, 16'hFFFE, 1'b1, 1'b0, 16'hFFFF, 16'h0001}};
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] or_r = 4'h0, bb = 4'h0, bbl = 4'h0;
    logic [15:0] sel = 16'h0000, prg = 16'h0000, lrg = 16'h0000;
    logic bw = 1'b0, bwl = 1'b0, inv = 1'b0, pz = 1'b0, os = 1'b0;
    logic rp = 1'b0, ret = 1'b1, br = 1'b0, st = 1'b0, cl = 1'b0;
    logic [15:0] img, mdl, wd, lat, fld, ew;
    logic ivs, osc, rs, fs, rpa, fpa, rse, fse, pv, po;
    logic [11:0] rseq = 12'h5B3, bseq = 12'h6A9;
    int n_mismatch = 0, num_checks = 0, cyc = 0;
    lce_eval dut (.i_sys_clk(clk), .i_rst_n(rst_n), .i_or_rungs(or_r),
        .i_or_target_sel(sel), .i_bow_rung(bw), .i_bow_bit(bb),
        .i_bow_rung_last(bwl), .i_bow_bit_last(bbl), .i_inv_rung(inv),
        .i_pause_rung(pz), .i_pause_range(prg), .i_os_rung(os),
        .i_ref_point(rp), .i_ref_retentive(ret), .i_branch_rung(br),
        .i_set_rung(st), .i_clr_rung(cl), .i_latch_range(lrg),
        .o_out_image(img), .o_out_module(mdl), .o_word(wd),
        .o_inv_status(ivs), .o_rising_one_shot_coil(osc),
        .o_rising_edge_start_contact(rs),
        .o_falling_edge_start_contact(fs),
        .o_rising_edge_parallel_contact(rpa),
        .o_falling_edge_parallel_contact(fpa),
        .o_rising_edge_series_contact(rse),
        .o_falling_edge_series_contact(fse), .o_latch_image(lat));
    lce_out_model u_out (.i_sys_clk(clk), .i_rst_n(rst_n),
        .i_drive(mdl), .o_field(fld));
    always #25 clk = ~clk;
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #5;
    endtask
    task automatic chk(input string nm, input logic [15:0] e,
        input logic [15:0] s);
        num_checks++;
        if (s !== e)
        begin
            n_mismatch++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, s);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 500)
        begin
            n_mismatch++;
            results();
        end
    end
    initial
    begin
        tick(16);
        chk("rst", 16'h0000, img | mdl | wd | lat);
        rst_n = 1'b1;
        tick(1);
        chk("entry", 16'h0001, rs);
        foreach (rows[i])
        begin
            or_r = rows[i].r;
            sel = rows[i].s;
            prg = rows[i].p;
            pz = rows[i].pz;
            inv = rows[i].iv;
            tick(3);
            chk("img", rows[i].ei, img);
            chk("mdl", rows[i].em, mdl);
            chk("fld", rows[i].em, fld);
            chk("inv", !rows[i].iv, ivs);
        end
        pv = 1'b0;
        po = 1'b0;
        for (int k = 0; k < 12; k++)
        begin
            rp = rseq[k];
            br = bseq[k];
            os = bseq[k];
            tick(1);
            chk("os", os && !po, osc);
            chk("rs", rp && !pv, rs);
            chk("fs", !rp && pv, fs);
            chk("rpa", br || (rp && !pv), rpa);
            chk("fpa", br || (!rp && pv), fpa);
            chk("rse", br && rp && !pv, rse);
            chk("fse", br && !rp && pv, fse);
            pv = rp;
            po = os;
        end
        ew = 16'h0000;
        bw = 1'b1;
        for (int b = 0; b < 16; b++)
        begin
            bb = 4'(b);
            bbl = bb + 4'h1;
            tick(1);
            ew[bb] = 1'b1;
            ew[bbl] = 1'b0;
            chk("word", ew, wd);
        end
        bb = 4'h5;
        bbl = 4'h5;
        tick(1);
        ew[5] = 1'b0;
        chk("last", ew, wd);
        bw = 1'b0;
        bwl = 1'b1;
        tick(1);
        ew[5] = 1'b1;
        chk("last", ew, wd);
        lrg = 16'h0FF0;
        st = 1'b1;
        tick(1);
        chk("set", 16'h0FF0, lat);
        st = 1'b0;
        tick(2);
        chk("hold", 16'h0FF0, lat);
        lrg = 16'h00F0;
        cl = 1'b1;
        tick(1);
        chk("clr", 16'h0F00, lat);
        cl = 1'b0;
        tick(2);
        chk("stay", 16'h0F00, lat);
        lrg = 16'h00FF;
        st = 1'b1;
        cl = 1'b1;
        tick(1);
        chk("both", 16'h0FFF, lat);
        st = 1'b0;
        cl = 1'b0;
        ret = 1'b0;
        rst_n = 1'b0;
        tick(2);
        chk("rst2", 16'h0000, img | mdl | wd | lat | fld);
        rst_n = 1'b1;
        tick(1);
        chk("entry2", 16'h0000, rs);
        results();
    end
endmodule
`default_nettype wire
